// ---- ppmp_core.sv ----
// Pad base pointer, two pad banks, held result registers and the pushed multiplier pipe.
`timescale 1ns/10ps
// Contract
// RQ1 - Pad offsets span minus four to plus three.
// RQ2 - Bump adds one, seen by next instruction.
// RQ3 - Pointer zeroed via scratch load or bus load.
// RQ4 - Zero pointer writes offset zero, then one.
// RQ5 - Multiplier advances once per issued multiply.
// RQ6 - Multiplier result keeps only latest emerged value.
// RQ7 - Memory and adder results hold until pushed.
// RQ8 - Pad location returns its latest write.
// RQ9 - Each pad bank holds 32 words.
// RQ10 - Pointer and offset sums wrap modulo 32.
module ppmp_core (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         bump_pad_pointer,
  input  wire logic                         load_pointer_from_scratch,
  input  wire logic                         clear_scratch_register,
  input  wire logic [ppmp_pkg::PTR_W-1:0]   scratch_value,
  input  wire logic                         load_pointer_from_bus,
  input  wire logic [ppmp_pkg::DATA_W-1:0]  data_bus,
  input  wire logic                         mem_push,
  input  wire logic [ppmp_pkg::DATA_W-1:0]  mem_data_in,
  input  wire logic                         adder_push,
  input  wire logic [ppmp_pkg::DATA_W-1:0]  adder_data_in,
  input  wire logic                         mul_issue,
  input  wire logic [ppmp_pkg::DATA_W-1:0]  mul_operand_a,
  input  wire logic [ppmp_pkg::DATA_W-1:0]  mul_operand_b,
  input  wire logic                         pad_x_wr_en,
  input  wire ppmp_pkg::ppmp_src_t          pad_x_wr_src,
  input  wire logic [ppmp_pkg::OFF_W-1:0]   pad_x_wr_off,
  input  wire logic [ppmp_pkg::OFF_W-1:0]   pad_x_rd_off,
  input  wire logic                         pad_bank_y_wr_en,
  input  wire ppmp_pkg::ppmp_src_t          pad_bank_y_wr_src,
  input  wire logic [ppmp_pkg::OFF_W-1:0]   pad_bank_y_wr_off,
  input  wire logic [ppmp_pkg::OFF_W-1:0]   pad_bank_y_rd_off,
  output logic      [ppmp_pkg::PTR_W-1:0]   pad_base_pointer_q,
  output logic      [ppmp_pkg::DATA_W-1:0]  memory_read_data_q,
  output logic      [ppmp_pkg::DATA_W-1:0]  adder_result_q,
  output logic      [ppmp_pkg::DATA_W-1:0]  multiplier_result_q,
  output logic      [ppmp_pkg::DATA_W-1:0]  pad_x_rdata_q,
  output logic      [ppmp_pkg::DATA_W-1:0]  pad_bank_y_rdata_q
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [ppmp_pkg::PTR_W-1:0]  pad_base_pointer_d;  // Next pointer value.
  logic [ppmp_pkg::DATA_W-1:0] memory_read_data_d;  // Next memory data register.
  logic [ppmp_pkg::DATA_W-1:0] adder_result_d;      // Next adder result register.
  logic [ppmp_pkg::DATA_W-1:0] multiplier_result_d; // Next multiplier result register.
  logic [ppmp_pkg::DATA_W-1:0] mul_stage_q [ppmp_pkg::MUL_STAGES]; // Products in flight.
  logic [ppmp_pkg::DATA_W-1:0] mul_stage_d [ppmp_pkg::MUL_STAGES]; // Next products.
  logic [ppmp_pkg::DATA_W-1:0] mul_product;          // Product of this issue.
  logic [ppmp_pkg::PTR_W-1:0]  x_wr_addr;            // X bank write address.
  logic [ppmp_pkg::PTR_W-1:0]  x_rd_addr;            // X bank read address.
  logic [ppmp_pkg::PTR_W-1:0]  y_wr_addr;            // Y bank write address.
  logic [ppmp_pkg::PTR_W-1:0]  y_rd_addr;            // Y bank read address.
  logic [ppmp_pkg::DATA_W-1:0] x_wr_data;            // Selected X write data.
  logic [ppmp_pkg::DATA_W-1:0] y_wr_data;            // Selected Y write data.
  logic [ppmp_pkg::DATA_W-1:0] x_rd_data;            // Raw X read data.
  logic [ppmp_pkg::DATA_W-1:0] y_rd_data;            // Raw Y read data.

  // Pointer plus a three-bit signed offset, cut back to the bank width.
  // The sign extension limits reach to -4..+3 and the cut wraps modulo 32.
  function automatic logic [ppmp_pkg::PTR_W-1:0] pad_addr(
    input logic [ppmp_pkg::PTR_W-1:0] base,
    input logic [ppmp_pkg::OFF_W-1:0] off
  );
    logic [ppmp_pkg::PTR_W-1:0] ext;
    ext = {{(ppmp_pkg::PTR_W-ppmp_pkg::OFF_W){off[ppmp_pkg::OFF_W-1]}}, off}; // [RQ1]
    return ppmp_pkg::PTR_W'(base + ext); // [RQ10]
  endfunction

  // Pick the pad write source from the held result registers or the bus.
  function automatic logic [ppmp_pkg::DATA_W-1:0] pick_src(
    input ppmp_pkg::ppmp_src_t            sel,
    input logic [ppmp_pkg::DATA_W-1:0]    md,
    input logic [ppmp_pkg::DATA_W-1:0]    fa,
    input logic [ppmp_pkg::DATA_W-1:0]    fm,
    input logic [ppmp_pkg::DATA_W-1:0]    db
  );
    logic [ppmp_pkg::DATA_W-1:0] res;
    unique case (sel)
      ppmp_pkg::PPMP_SRC_MEM:   res = md;
      ppmp_pkg::PPMP_SRC_ADDER: res = fa;
      ppmp_pkg::PPMP_SRC_MUL:   res = fm;
      ppmp_pkg::PPMP_SRC_BUS:   res = db;
    endcase
    return res;
  endfunction

  // ****************************************************************
  // Pad base pointer
  // ****************************************************************
  // Loads take priority over a bump, since a load defines a fresh base and a
  // bump in the same instruction would make that base ambiguous.
  always_comb begin
    pad_base_pointer_d = pad_base_pointer_q;
    if (load_pointer_from_bus) begin
      pad_base_pointer_d = data_bus[ppmp_pkg::PTR_W-1:0]; // [RQ3]
    end else if (load_pointer_from_scratch) begin
      // A cleared scratch register copies as zero in the same instruction.
      pad_base_pointer_d = clear_scratch_register ? ppmp_pkg::PTR_RESET
                                                  : scratch_value; // [RQ3]
    end else if (bump_pad_pointer) begin
      pad_base_pointer_d = ppmp_pkg::PTR_W'(pad_base_pointer_q + 5'h01); // [RQ2] [RQ10]
    end
  end

  // Register the pointer; the new value serves only the next instruction.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_base_pointer_q <= ppmp_pkg::PTR_RESET;
    end else begin
      pad_base_pointer_q <= pad_base_pointer_d; // [RQ2]
    end
  end

  // ****************************************************************
  // Held result registers and the multiplier pipe
  // ****************************************************************
  assign mul_product = ppmp_pkg::DATA_W'(mul_operand_a * mul_operand_b);

  // Results move only on a push; no push means the registers hold.
  always_comb begin
    memory_read_data_d  = mem_push   ? mem_data_in   : memory_read_data_q; // [RQ7]
    adder_result_d      = adder_push ? adder_data_in : adder_result_q;     // [RQ7]
    multiplier_result_d = multiplier_result_q;
    for (int s = 0; s < ppmp_pkg::MUL_STAGES; s++) begin
      mul_stage_d[s] = mul_stage_q[s];
    end
    // Every issue, whatever its operands, moves the whole pipe one step.
    if (mul_issue) begin
      mul_stage_d[0] = mul_product; // [RQ5]
      for (int s = 1; s < ppmp_pkg::MUL_STAGES; s++) begin
        mul_stage_d[s] = mul_stage_q[s-1]; // [RQ5]
      end
      // The emerging product overwrites the last one, which is lost.
      multiplier_result_d = mul_stage_q[ppmp_pkg::MUL_STAGES-1]; // [RQ6]
    end
  end

  // Register the results and the products in flight.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      memory_read_data_q  <= ppmp_pkg::DATA_RESET;
      adder_result_q      <= ppmp_pkg::DATA_RESET;
      multiplier_result_q <= ppmp_pkg::DATA_RESET;
      for (int s = 0; s < ppmp_pkg::MUL_STAGES; s++) begin
        mul_stage_q[s] <= ppmp_pkg::DATA_RESET;
      end
    end else begin
      memory_read_data_q  <= memory_read_data_d;
      adder_result_q      <= adder_result_d;
      multiplier_result_q <= multiplier_result_d;
      for (int s = 0; s < ppmp_pkg::MUL_STAGES; s++) begin
        mul_stage_q[s] <= mul_stage_d[s];
      end
    end
  end

  // ****************************************************************
  // Pad banks
  // ****************************************************************
  // Addresses use the pointer as it stands, so a bump never moves the
  // accesses of its own instruction.
  always_comb begin
    x_wr_addr = pad_addr(pad_base_pointer_q, pad_x_wr_off);      // [RQ1] [RQ4]
    x_rd_addr = pad_addr(pad_base_pointer_q, pad_x_rd_off);      // [RQ1]
    y_wr_addr = pad_addr(pad_base_pointer_q, pad_bank_y_wr_off); // [RQ1]
    y_rd_addr = pad_addr(pad_base_pointer_q, pad_bank_y_rd_off); // [RQ1]
    x_wr_data = pick_src(pad_x_wr_src, memory_read_data_q, adder_result_q,
                         multiplier_result_q, data_bus);
    y_wr_data = pick_src(pad_bank_y_wr_src, memory_read_data_q, adder_result_q,
                         multiplier_result_q, data_bus);
  end

  // The X bank, 32 words. [RQ9]
  ppmp_pad_bank u_pad_x (
    .clk     (clk),
    .arst_n  (arst_n),
    .wr_en   (pad_x_wr_en),
    .wr_addr (x_wr_addr),
    .wr_data (x_wr_data),
    .rd_addr (x_rd_addr),
    .rd_data (x_rd_data)
  );

  // The Y bank, 32 words. [RQ9]
  ppmp_pad_bank u_pad_y (
    .clk     (clk),
    .arst_n  (arst_n),
    .wr_en   (pad_bank_y_wr_en),
    .wr_addr (y_wr_addr),
    .wr_data (y_wr_data),
    .rd_addr (y_rd_addr),
    .rd_data (y_rd_data)
  );

  // Read data is registered so that every output leaves a flip-flop.
  // The trade is one cycle of read latency; a write in the same cycle is
  // not seen until the following read.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_x_rdata_q      <= ppmp_pkg::DATA_RESET;
      pad_bank_y_rdata_q <= ppmp_pkg::DATA_RESET;
    end else begin
      pad_x_rdata_q      <= x_rd_data; // [RQ8]
      pad_bank_y_rdata_q <= y_rd_data; // [RQ8]
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Helpers for the checks below: pointer plus one and pointer distance.
  function automatic logic [ppmp_pkg::PTR_W-1:0] ptr_plus1(
    input logic [ppmp_pkg::PTR_W-1:0] p
  );
    return ppmp_pkg::PTR_W'(p + 5'h01);
  endfunction

  function automatic logic [ppmp_pkg::PTR_W-1:0] ptr_diff(
    input logic [ppmp_pkg::PTR_W-1:0] a,
    input logic [ppmp_pkg::PTR_W-1:0] b
  );
    return ppmp_pkg::PTR_W'(a - b);
  endfunction

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_ptr_bump_next: assert property ( // [RQ2]
    (bump_pad_pointer && !load_pointer_from_bus && !load_pointer_from_scratch)
      |=> pad_base_pointer_q == ptr_plus1($past(pad_base_pointer_q)))
    else $error("Pointer did not advance by one after a bump.");

  a_ptr_bus_zero: assert property ( // [RQ3]
    // Only the low bits reach the pointer, so upper bus bits must not matter.
    (load_pointer_from_bus && data_bus[ppmp_pkg::PTR_W-1:0] == 5'h00)
      |=> pad_base_pointer_q == 5'h00)
    else $error("Bus load of zero did not clear the pointer.");

  a_ptr_scratch_clr: assert property ( // [RQ3]
    (load_pointer_from_scratch && clear_scratch_register && !load_pointer_from_bus)
      |=> pad_base_pointer_q == 5'h00)
    else $error("Cleared scratch load did not zero the pointer.");

  a_addr_offset_range: assert property ( // [RQ1]
    ptr_diff(x_wr_addr, pad_base_pointer_q) inside {5'h1c, 5'h1d, 5'h1e, 5'h1f,
                                                    5'h00, 5'h01, 5'h02, 5'h03})
    else $error("Pad address left the -4..+3 window.");

  a_pad_fill_seq: assert property ( // [RQ4]
    (pad_base_pointer_q == 5'h00 && pad_x_wr_en && pad_x_wr_off == 3'h0 && bump_pad_pointer
     && !load_pointer_from_bus && !load_pointer_from_scratch)
      ##1 (pad_x_wr_en && pad_x_wr_off == 3'h0) |-> x_wr_addr == 5'h01)
    else $error("Write after bump did not land at location one.");

  a_mul_hold_idle: assert property ( // [RQ5]
    !mul_issue |=> $stable(multiplier_result_q))
    else $error("Multiplier result moved without an issued multiply.");

  a_mul_three_push: assert property ( // [RQ6]
    (mul_issue ##1 mul_issue ##1 mul_issue) |=> multiplier_result_q == $past(mul_product, 3))
    else $error("Product did not emerge at the third issued multiply.");

  a_result_hold: assert property ( // [RQ7]
    (!mem_push && !adder_push)[*2] |=> ($stable(memory_read_data_q) && $stable(adder_result_q)))
    else $error("Held result register changed without a push.");

  a_pad_last_write: assert property ( // [RQ8]
    (pad_x_wr_en ##1 (x_rd_addr == $past(x_wr_addr))) |=> pad_x_rdata_q == $past(x_wr_data, 2))
    else $error("Pad read did not return the latest write.");

  c_bump_run: cover property (bump_pad_pointer [*4]);
  c_mul_push: cover property (mul_issue ##1 mul_issue ##1 mul_issue);
  c_overwrite: cover property (pad_x_wr_en ##1 pad_x_wr_en && x_wr_addr == $past(x_wr_addr));

endmodule

// ---- ppmp_core_bench.sv ----
// Self-checking random and directed bench for the pad pointer and multiplier push block.
`timescale 1ns/10ps
module ppmp_core_bench;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic                 clk = 1'b0;  // Bench clock, 25 ns period.
  logic                 arst_n;      // Active low reset.
  logic                 bump, lsc, clr, lbus, mpush, apush, mi, xwe, ywe; // Commands.
  logic [4:0]           sv;          // Scratch register value.
  logic [31:0]          db, mdin, adin, ma, mb;                 // Data inputs.
  ppmp_pkg::ppmp_src_t  xsrc, ysrc;  // Pad write sources.
  logic [2:0]           xwo, xro, ywo, yro;                     // Signed offsets.
  logic [4:0]           ptr_q;       // Pointer seen at the port.
  logic [31:0]          md_q, fa_q, fm_q, xr_q, yr_q;           // Outputs seen.
  logic [31:0]          seed = 32'h7d15f9cf; // Random state, fixed start.
  int                   n_errors = 0;     // Mismatches counted.
  int                   check_count = 0;  // Comparisons made.
  // Expected state kept by the bench.
  logic [4:0]           e_ptr;
  logic [31:0]          e_md, e_fa, e_fm, s1, s2, e_xr, e_yr;
  logic [31:0]          mx [32];
  logic [31:0]          my [32];

  always #12.5 clk = ~clk;

  ppmp_core i_dut (
    .clk(clk), .arst_n(arst_n), .bump_pad_pointer(bump),
    .load_pointer_from_scratch(lsc), .clear_scratch_register(clr), .scratch_value(sv),
    .load_pointer_from_bus(lbus), .data_bus(db), .mem_push(mpush), .mem_data_in(mdin),
    .adder_push(apush), .adder_data_in(adin), .mul_issue(mi), .mul_operand_a(ma),
    .mul_operand_b(mb), .pad_x_wr_en(xwe), .pad_x_wr_src(xsrc), .pad_x_wr_off(xwo),
    .pad_x_rd_off(xro), .pad_bank_y_wr_en(ywe), .pad_bank_y_wr_src(ysrc),
    .pad_bank_y_wr_off(ywo), .pad_bank_y_rd_off(yro), .pad_base_pointer_q(ptr_q),
    .memory_read_data_q(md_q), .adder_result_q(fa_q), .multiplier_result_q(fm_q),
    .pad_x_rdata_q(xr_q), .pad_bank_y_rdata_q(yr_q)
  );

  // ****************************************************************
  // Expectation functions
  // ****************************************************************
  // Next random value; a simple shift register keeps the run repeatable.
  function automatic logic [31:0] lfsr_next(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Pad address: base plus sign-extended offset, wrapping inside the bank.
  function automatic logic [4:0] at(logic [4:0] b, logic [2:0] o);
    return b + {{2{o[2]}}, o};
  endfunction

  // Pad write data for a source, taken from the held values before this edge.
  function automatic logic [31:0] pick(ppmp_pkg::ppmp_src_t s);
    case (s)
      ppmp_pkg::PPMP_SRC_MEM:   return e_md;
      ppmp_pkg::PPMP_SRC_ADDER: return e_fa;
      ppmp_pkg::PPMP_SRC_MUL:   return e_fm;
      default:                  return db;
    endcase
  endfunction

  // ****************************************************************
  // Reference model, updated at each rising edge
  // ****************************************************************
  // Reads use the contents before the write of the same edge, as the registered read does.
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {e_ptr, e_md, e_fa, e_fm, s1, s2, e_xr, e_yr} = '0;
      for (int i = 0; i < 32; i++) begin
        mx[i] = '0;
        my[i] = '0;
      end
    end else begin
      e_xr = mx[at(e_ptr, xro)];
      e_yr = my[at(e_ptr, yro)];
      if (xwe) mx[at(e_ptr, xwo)] = pick(xsrc);
      if (ywe) my[at(e_ptr, ywo)] = pick(ysrc);
      if (mi) begin
        e_fm = s2;
        s2 = s1;
        s1 = ma * mb;
      end
      if (mpush) e_md = mdin;
      if (apush) e_fa = adin;
      if (lbus) e_ptr = db[4:0];
      else if (lsc) e_ptr = clr ? 5'h00 : sv;
      else if (bump) e_ptr = e_ptr + 5'h01;
    end
  end

  // ****************************************************************
  // Comparison, on the falling edge where outputs have settled
  // ****************************************************************
  task automatic chk(logic [31:0] got, logic [31:0] exp, string m);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask

  always @(negedge clk) begin
    chk({27'h0, ptr_q}, {27'h0, e_ptr}, "pointer");
    chk(md_q, e_md, "memory data");
    chk(fa_q, e_fa, "adder result");
    chk(fm_q, e_fm, "multiplier result");
    chk(xr_q, e_xr, "x read");
    chk(yr_q, e_yr, "y read");
  end

  // ****************************************************************
  // Stimulus tasks
  // ****************************************************************
  // One instruction slot: inputs change a fixed 1 ns after the rising edge.
  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // All commands off, so a directed step sets only what it means.
  task automatic idle();
    {bump, lsc, clr, lbus, mpush, apush, mi, xwe, ywe} = '0;
    xsrc = ppmp_pkg::PPMP_SRC_MEM;
    ysrc = ppmp_pkg::PPMP_SRC_MEM;
  endtask

  // Fully random instruction; loads are made rarer so the pointer mostly walks.
  task automatic rand_cycle();
    logic [31:0] r;
    seed = lfsr_next(seed); r = seed;
    bump = r[0]; lsc = r[1] & r[2]; clr = r[3]; sv = r[8:4];
    lbus = r[9] & r[10] & r[11]; mpush = r[12]; apush = r[13]; mi = r[14];
    xwe = r[15]; xsrc = ppmp_pkg::ppmp_src_t'(r[17:16]); xwo = r[20:18]; xro = r[23:21];
    ywe = r[24]; ysrc = ppmp_pkg::ppmp_src_t'(r[26:25]); ywo = r[29:27];
    seed = lfsr_next(seed); yro = seed[2:0]; db = seed;
    seed = lfsr_next(seed); mdin = seed;
    seed = lfsr_next(seed); adin = seed;
    seed = lfsr_next(seed); ma = seed;
    seed = lfsr_next(seed); mb = seed;
  endtask

  // Single place where the run ends.
  task automatic report_and_stop();
    if (n_errors == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    arst_n = 1'b0;
    idle();
    {sv, db, mdin, adin, ma, mb, xwo, xro, ywo, yro} = '0;
    repeat (20) @(posedge clk);
    #1 arst_n = 1'b1;
    tick();
    // Pointer cleared through a cleared scratch value while scratch holds all ones.
    lsc = 1'b1; clr = 1'b1; sv = 5'h1f; tick();
    // Store a vector at offset zero with a bump each slot: words 0, 1, 2 ...
    for (int i = 0; i < 8; i++) begin
      idle(); xwe = 1'b1; xwo = 3'h0; bump = 1'b1; mpush = 1'b1; mdin = 32'h1000 + i;
      tick();
    end
    // Bus load of zero with upper bus bits set; scratch load and bump lose to it.
    idle(); lbus = 1'b1; lsc = 1'b1; bump = 1'b1; sv = 5'h0a; db = 32'hffffffe0; tick();
    // Every read offset from minus four to plus three, wrapping below zero.
    for (int o = 0; o < 8; o++) begin
      idle(); xro = o[2:0]; yro = o[2:0]; tick();
    end
    // Memory then adder data into one word, then read: the adder value wins.
    idle(); apush = 1'b1; adin = 32'hadd0add0; tick();
    xwe = 1'b1; xsrc = ppmp_pkg::PPMP_SRC_MEM; xwo = 3'h1; apush = 1'b0; tick();
    xsrc = ppmp_pkg::PPMP_SRC_ADDER; tick();
    idle(); xro = 3'h1; tick();
    // Every write source into both banks.
    for (int s = 0; s < 4; s++) begin
      idle(); xwe = 1'b1; ywe = 1'b1; xsrc = ppmp_pkg::ppmp_src_t'(s);
      ysrc = ppmp_pkg::ppmp_src_t'(s); xwo = s[2:0]; ywo = 3'h7 - s[2:0]; db = 32'hd0 + s;
      tick();
    end
    // Multiplies with idle gaps: results move per issue, not per cycle.
    for (int i = 0; i < 10; i++) begin
      idle(); mi = (i % 3 != 1); ma = i + 3; mb = 32'h10001 * i; tick();
    end
    idle();
    repeat (4) tick();
    // Random traffic with a reset in the middle.
    for (int n = 0; n < 3000; n++) begin
      if (n == 1500) begin
        arst_n = 1'b0;
        repeat (3) tick();
        arst_n = 1'b1;
      end
      rand_cycle();
      tick();
    end
    idle();
    tick();
    report_and_stop();
  end
endmodule

// ---- ppmp_pad_bank.sv ----
// One scratch pad bank: flip-flop storage with one write and one read port.
`timescale 1ns/10ps
module ppmp_pad_bank (
  input  wire logic                         clk,
  input  wire logic                         arst_n,
  input  wire logic                         wr_en,
  input  wire logic [ppmp_pkg::PTR_W-1:0]   wr_addr,
  input  wire logic [ppmp_pkg::DATA_W-1:0]  wr_data,
  input  wire logic [ppmp_pkg::PTR_W-1:0]   rd_addr,
  output logic      [ppmp_pkg::DATA_W-1:0]  rd_data
);

  // Storage words and their next values.
  logic [ppmp_pkg::DATA_W-1:0] mem_q [ppmp_pkg::PAD_DEPTH];
  logic [ppmp_pkg::DATA_W-1:0] mem_d [ppmp_pkg::PAD_DEPTH];

  // ****************************************************************
  // Storage, one generate entry per word
  // ****************************************************************
  for (genvar i = 0; i < ppmp_pkg::PAD_DEPTH; i++) begin : g_word
    // The newest write of any source replaces the word. [RQ8]
    always_comb begin
      mem_d[i] = mem_q[i];
      if (wr_en && (wr_addr == ppmp_pkg::PTR_W'(i))) begin
        mem_d[i] = wr_data; // [RQ8]
      end
    end

    // Register the word.
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        mem_q[i] <= ppmp_pkg::DATA_RESET;
      end else begin
        mem_q[i] <= mem_d[i];
      end
    end
  end

  // Read is combinational; the caller registers it.
  assign rd_data = mem_q[rd_addr];

endmodule

// ---- ppmp_pkg.sv ----
// Shared constants and types for the pad pointer and multiplier push block.
package ppmp_pkg;

  // ****************************************************************
  // Widths and depths
  // ****************************************************************
  localparam int unsigned DATA_W     = 32; // Width of one pad word and of every result.
  localparam int unsigned PTR_W      = 5;  // Width of the pad base pointer.
  localparam int unsigned OFF_W      = 3;  // Width of a signed pad offset.
  localparam int unsigned PAD_DEPTH  = 32; // Words in each pad bank.
  localparam int unsigned MUL_STAGES = 2;  // Internal multiplier stages before the result.

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PTR_W-1:0]  PTR_RESET  = 5'h00;        // Pointer value after reset.
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h00000000; // Result registers after reset.

  // Source selected for a write into a pad bank.
  typedef enum logic [1:0] {
    PPMP_SRC_MEM   = 2'h0, // Memory read data register.
    PPMP_SRC_ADDER = 2'h1, // Adder result register.
    PPMP_SRC_MUL   = 2'h2, // Multiplier result register.
    PPMP_SRC_BUS   = 2'h3  // Data bus.
  } ppmp_src_t;

endpackage
